// *** ars_scaler.sv ***
// Purpose: scales raw converter codes of four lines into signed units
// Assumes: converter and register port synchronous to ref_clk
// Notes: commands use staged argument registers, then a command write
//
// The register addresses and the address-and-strobe port are this design's own decisions.
`timescale 1ns/100ps
module ars_scaler (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rstn,
  // Register port
  input wire logic [7:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  // Converter side
  input wire logic adc_valid,
  input wire logic [2:0] adc_line,
  input wire logic [7:0] adc_code,
  output logic adc_ready,
  // Scaled readings
  output logic rdg_valid,
  output logic [2:0] rdg_line,
  output logic signed [17:0] rdg_value,
  output logic [1:0] rdg_decimals,
  output logic rdg_divided
);
  localparam int N = ars_pkg::NLINES;
  // ***************************************************
  // Declarations
  // ***************************************************
  logic [2:0] line_sel_r, line_sel_nxt;
  logic [20:0] zero_arg_r, zero_arg_nxt;
  logic [20:0] full_arg_r, full_arg_nxt;
  logic [19:0] cal_arg_r, cal_arg_nxt;
  logic [2:0] prec_arg_r, prec_arg_nxt;
  logic signed [14:0] zero_r [N];
  logic signed [14:0] zero_nxt [N];
  logic signed [14:0] full_r [N];
  logic signed [14:0] full_nxt [N];
  logic [1:0] prec_r [N];
  logic [1:0] prec_nxt [N];
  logic div_r [N];
  logic div_nxt [N];
  logic signed [15:0] offs_r [N];
  logic signed [15:0] offs_nxt [N];
  logic signed [15:0] conv_r [N];
  logic signed [15:0] conv_nxt [N];
  logic err_r, err_nxt, ok_r, ok_nxt;
  ars_pkg::ars_state_type state_r, state_nxt;
  logic [1:0] cur_r, cur_nxt;
  logic ready_r, ready_nxt;
  logic rvalid_r, rvalid_nxt;
  logic [2:0] rline_r, rline_nxt;
  logic signed [17:0] rvalue_r, rvalue_nxt;
  logic [1:0] rdec_r, rdec_nxt;
  logic rdiv_r, rdiv_nxt;
  logic [31:0] rdata_r, rdata_nxt;
  logic signed [14:0] zd_value, fd_value, cd_value;
  logic zd_reset, fd_reset, cd_reset;
  logic zd_bad, fd_bad, cd_bad;
  logic cmd_wr, lok, prec_ok, pts_ok, cal_ok, cmd_ok;
  logic [3:0] cmd_code;
  logic [1:0] li, ai;
  logic start, i_done;
  logic signed [15:0] i_value, conv_sel;
  logic signed [16:0] res_sel;
  // ***************************************************
  // Argument decoders
  // ***************************************************
  ars_digits u_zero_dig (
    .sign_dig(zero_arg_r[ars_pkg::SIGN_LSB +: 4]),
    .mag_bcd(zero_arg_r[15:0]),
    .value(zd_value),
    .is_reset(zd_reset),
    .bad(zd_bad)
  );
  ars_digits u_full_dig (
    .sign_dig(full_arg_r[ars_pkg::SIGN_LSB +: 4]),
    .mag_bcd(full_arg_r[15:0]),
    .value(fd_value),
    .is_reset(fd_reset),
    .bad(fd_bad)
  );
  ars_digits u_cal_dig (
    .sign_dig(cal_arg_r[ars_pkg::SIGN_LSB +: 4]),
    .mag_bcd(cal_arg_r[15:0]),
    .value(cd_value),
    .is_reset(cd_reset),
    .bad(cd_bad)
  );
  // ***************************************************
  // Command decode and per-line settings
  // ***************************************************
  always_comb
  begin
    cmd_wr = reg_wr && reg_addr == ars_pkg::A_COMMAND;
    cmd_code = reg_wdata[3:0];
    lok = ars_pkg::line_ok(line_sel_r);
    li = ars_pkg::line_idx(line_sel_r);
    conv_sel = conv_r[li];
    res_sel = 17'(conv_sel) + 17'(offs_r[li]);
    prec_ok = lok && prec_arg_r <= ars_pkg::PREC_MAX;
    pts_ok = lok && !zd_bad && !fd_bad && !zd_reset && !fd_reset;
    cal_ok = lok && !cd_bad;
    case (cmd_code)
      ars_pkg::CMD_PREC: cmd_ok = prec_ok;
      ars_pkg::CMD_POINTS: cmd_ok = pts_ok;
      ars_pkg::CMD_CAL: cmd_ok = cal_ok;
      default: cmd_ok = 1'b0;
    endcase
    line_sel_nxt = line_sel_r;
    zero_arg_nxt = zero_arg_r;
    full_arg_nxt = full_arg_r;
    cal_arg_nxt = cal_arg_r;
    prec_arg_nxt = prec_arg_r;
    zero_nxt = zero_r;
    full_nxt = full_r;
    prec_nxt = prec_r;
    div_nxt = div_r;
    offs_nxt = offs_r;
    err_nxt = err_r;
    ok_nxt = ok_r;
    if (reg_wr)
    begin
      case (reg_addr)
        ars_pkg::A_LINE_SEL: line_sel_nxt = reg_wdata[2:0];
        ars_pkg::A_ZERO_ARG: zero_arg_nxt = reg_wdata[20:0];
        ars_pkg::A_FULL_ARG: full_arg_nxt = reg_wdata[20:0];
        ars_pkg::A_CAL_ARG: cal_arg_nxt = reg_wdata[19:0];
        ars_pkg::A_PREC_ARG: prec_arg_nxt = reg_wdata[2:0];
        default: line_sel_nxt = line_sel_r;
      endcase
    end
    if (cmd_wr)
    begin
      err_nxt = !cmd_ok;
      ok_nxt = cmd_ok;
    end
    if (cmd_wr && cmd_ok)
    begin
      case (cmd_code)
        ars_pkg::CMD_PREC:
        begin
          // Decimals only label the result; the math is pure integer
          prec_nxt[li] = prec_arg_r[1:0];
        end
        ars_pkg::CMD_POINTS:
        begin
          zero_nxt[li] = zd_value;
          full_nxt[li] = fd_value;
          // Divider only rescales the meaning of full scale
          div_nxt[li] = full_arg_r[ars_pkg::DIV_BIT];
        end
        default:
        begin
          if (cd_reset)
            offs_nxt[li] = 16'sh0000;
          else
            offs_nxt[li] = 16'(cd_value) - conv_sel;
        end
      endcase
    end
  end
  always_ff @(posedge ref_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      line_sel_r <= 3'h1;
      zero_arg_r <= 21'h000000;
      full_arg_r <= 21'h000000;
      cal_arg_r <= 20'h00000;
      prec_arg_r <= 3'h0;
      err_r <= 1'b0;
      ok_r <= 1'b0;
      for (int i = 0; i < N; i++)
      begin
        zero_r[i] <= ars_pkg::RST_ZERO;
        full_r[i] <= ars_pkg::RST_FULL;
        prec_r[i] <= ars_pkg::RST_PREC;
        div_r[i] <= 1'b0;
        offs_r[i] <= 16'sh0000;
      end
    end
    else
    begin
      line_sel_r <= line_sel_nxt;
      zero_arg_r <= zero_arg_nxt;
      full_arg_r <= full_arg_nxt;
      cal_arg_r <= cal_arg_nxt;
      prec_arg_r <= prec_arg_nxt;
      err_r <= err_nxt;
      ok_r <= ok_nxt;
      zero_r <= zero_nxt;
      full_r <= full_nxt;
      prec_r <= prec_nxt;
      div_r <= div_nxt;
      offs_r <= offs_nxt;
    end
  end
  // ***************************************************
  // Conversion sequence
  // ***************************************************
  ars_interp u_interp (
    .ref_clk(ref_clk),
    .rstn(rstn),
    .start(start),
    .zero_pt(zero_r[ai]),
    .full_pt(full_r[ai]),
    .code(adc_code),
    .done(i_done),
    .value(i_value)
  );
  always_comb
  begin
    ai = ars_pkg::line_idx(adc_line);
    start = 1'b0;
    state_nxt = state_r;
    cur_nxt = cur_r;
    ready_nxt = ready_r;
    conv_nxt = conv_r;
    rvalid_nxt = 1'b0;
    rline_nxt = rline_r;
    rvalue_nxt = rvalue_r;
    rdec_nxt = rdec_r;
    rdiv_nxt = rdiv_r;
    case (state_r)
      ars_pkg::ST_IDLE:
      begin
        // Codes for a line outside one to four are dropped
        if (adc_valid && ars_pkg::line_ok(adc_line))
        begin
          start = 1'b1;
          cur_nxt = ai;
          ready_nxt = 1'b0;
          state_nxt = ars_pkg::ST_CONV;
        end
      end
      ars_pkg::ST_CONV:
      begin
        if (i_done)
        begin
          conv_nxt[cur_r] = i_value;
          rvalid_nxt = 1'b1;
          rline_nxt = 3'({1'b0, cur_r}) + 3'h1;
          // Correction goes on after interpolation, so points stay independent
          rvalue_nxt = 18'(i_value) + 18'(offs_r[cur_r]);
          rdec_nxt = prec_r[cur_r];
          rdiv_nxt = div_r[cur_r];
          ready_nxt = 1'b1;
          state_nxt = ars_pkg::ST_IDLE;
        end
      end
      default:
      begin
        ready_nxt = 1'b1;
        state_nxt = ars_pkg::ST_IDLE;
      end
    endcase
  end
  always_ff @(posedge ref_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      state_r <= ars_pkg::ST_IDLE;
      cur_r <= 2'h0;
      ready_r <= 1'b1;
      rvalid_r <= 1'b0;
      rline_r <= 3'h1;
      rvalue_r <= 18'sh00000;
      rdec_r <= 2'h0;
      rdiv_r <= 1'b0;
      for (int i = 0; i < N; i++)
        conv_r[i] <= 16'sh0000;
    end
    else
    begin
      state_r <= state_nxt;
      cur_r <= cur_nxt;
      ready_r <= ready_nxt;
      rvalid_r <= rvalid_nxt;
      rline_r <= rline_nxt;
      rvalue_r <= rvalue_nxt;
      rdec_r <= rdec_nxt;
      rdiv_r <= rdiv_nxt;
      conv_r <= conv_nxt;
    end
  end
  // ***************************************************
  // Register readback
  // ***************************************************
  always_comb
  begin
    rdata_nxt = 32'h00000000;
    if (reg_rd)
    begin
      case (reg_addr)
        ars_pkg::A_LINE_SEL: rdata_nxt = 32'(line_sel_r);
        ars_pkg::A_ZERO_ARG: rdata_nxt = 32'(zero_arg_r);
        ars_pkg::A_FULL_ARG: rdata_nxt = 32'(full_arg_r);
        ars_pkg::A_CAL_ARG: rdata_nxt = 32'(cal_arg_r);
        ars_pkg::A_PREC_ARG: rdata_nxt = 32'(prec_arg_r);
        ars_pkg::A_STATUS:
        begin
          rdata_nxt[ars_pkg::ST_BUSY] = state_r == ars_pkg::ST_CONV;
          rdata_nxt[ars_pkg::ST_ERR] = err_r;
          rdata_nxt[ars_pkg::ST_OK] = ok_r;
        end
        ars_pkg::A_RESULT: rdata_nxt = 32'(res_sel);
        ars_pkg::A_OFFSET: rdata_nxt = 32'(offs_r[li]);
        ars_pkg::A_LINE_CFG:
        begin
          rdata_nxt[1:0] = prec_r[li];
          rdata_nxt[ars_pkg::CFG_DIV] = div_r[li];
        end
        default: rdata_nxt = 32'h00000000;
      endcase
    end
  end
  always_ff @(posedge ref_clk or negedge rstn)
  begin
    if (!rstn)
      rdata_r <= 32'h00000000;
    else
      rdata_r <= rdata_nxt;
  end
  assign reg_rdata = rdata_r;
  assign adc_ready = ready_r;
  assign rdg_valid = rvalid_r;
  assign rdg_line = rline_r;
  assign rdg_value = rvalue_r;
  assign rdg_decimals = rdec_r;
  assign rdg_divided = rdiv_r;
  // ***************************************************
  // Checks
  // ***************************************************
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (!rstn);
  sequence s_sample_taken;
    adc_valid && ready_r && ars_pkg::line_ok(adc_line);
  endsequence
  sequence s_cal_set;
    cmd_wr && cmd_code == ars_pkg::CMD_CAL && cal_ok && !cd_reset && !i_done;
  endsequence
  a_reading_latency:
    assert property (s_sample_taken |=> !ready_r [*8] ##17 (rvalid_r && ready_r))
    else $error("reading not delivered 25 cycles after sample");
  a_reading_line:
    assert property (rvalid_r |-> ars_pkg::line_ok(rline_r) && rline_r == $past(adc_line, 25))
    else $error("reading carries a bad line number");
  a_cal_target:
    assert property (s_cal_set |=> res_sel == 17'($past(cd_value)))
    else $error("correction does not reach the given value");
  a_cal_reset:
    assert property (cmd_wr && cmd_code == ars_pkg::CMD_CAL && cal_ok && cd_reset |=> offs_r[$past(li)] == 16'sh0000)
    else $error("reset form left a correction");
  a_bad_command:
    assert property (cmd_wr && !cmd_ok |=> err_r && !ok_r && $stable(prec_r[li]))
    else $error("rejected command changed state");
  a_points_store:
    assert property (cmd_wr && cmd_code == ars_pkg::CMD_POINTS && pts_ok |=> zero_r[$past(li)] == $past(zd_value))
    else $error("zero point not stored");
  a_rdata_window:
    assert property (!$past(reg_rd) |-> rdata_r == 32'h00000000)
    else $error("read data outside its cycle");
endmodule : ars_scaler

// *** ars_pkg.sv ***
// Purpose: shared constants and types for the analog reading scaler
// Assumes: one clock, registers on a plain strobe port
// Notes: all values are signed integers with implied decimal places
package ars_pkg;
  // ***************************************************
  // Sizes
  // ***************************************************
  localparam int NLINES = 4;
  localparam int DVD_W = 23;
  localparam logic [4:0] DIV_STEPS = 5'h17;
  // Raw code spans 255 steps from zero point to full scale
  localparam logic [8:0] ADC_DIVISOR = 9'h0FF;
  localparam logic [22:0] ROUND_HALF = 23'h00007F;
  // ***************************************************
  // Register byte offsets
  // ***************************************************
  localparam logic [7:0] A_LINE_SEL = 8'h00;
  localparam logic [7:0] A_ZERO_ARG = 8'h04;
  localparam logic [7:0] A_FULL_ARG = 8'h08;
  localparam logic [7:0] A_CAL_ARG = 8'h0C;
  localparam logic [7:0] A_PREC_ARG = 8'h10;
  localparam logic [7:0] A_COMMAND = 8'h14;
  localparam logic [7:0] A_STATUS = 8'h18;
  localparam logic [7:0] A_RESULT = 8'h1C;
  localparam logic [7:0] A_OFFSET = 8'h20;
  localparam logic [7:0] A_LINE_CFG = 8'h24;
  // ***************************************************
  // Fields and codes
  // ***************************************************
  localparam int SIGN_LSB = 16;
  localparam int DIV_BIT = 20;
  localparam int ST_BUSY = 0;
  localparam int ST_ERR = 1;
  localparam int ST_OK = 2;
  localparam int CFG_DIV = 4;
  localparam logic [3:0] SIGN_NEG = 4'h1;
  localparam logic [3:0] SIGN_RESET = 4'h2;
  localparam logic [3:0] CMD_PREC = 4'h1;
  localparam logic [3:0] CMD_POINTS = 4'h2;
  localparam logic [3:0] CMD_CAL = 4'h3;
  localparam logic [2:0] PREC_MAX = 3'h3;
  localparam logic [14:0] RST_ZERO = 15'h0000;
  localparam logic [14:0] RST_FULL = 15'h0005;
  localparam logic [1:0] RST_PREC = 2'h0;
  typedef enum logic [1:0] {ST_IDLE = 2'h1, ST_CONV = 2'h2} ars_state_type;
  // Line numbers run from one to four
  function automatic logic line_ok(input logic [2:0] n);
    return (n >= 3'h1) && (n <= 3'h4);
  endfunction : line_ok
  function automatic logic [1:0] line_idx(input logic [2:0] n);
    return 2'(n - 3'h1);
  endfunction : line_idx
endpackage : ars_pkg

// *** ars_digits.sv ***
// Purpose: sign digit plus four BCD digits to a signed integer
// Assumes: digits arrive packed, most significant first
// Notes: purely combinational
`timescale 1ns/100ps
module ars_digits (
  // Digit fields
  input wire logic [3:0] sign_dig,
  input wire logic [15:0] mag_bcd,
  // Decoded value
  output logic signed [14:0] value,
  output logic is_reset,
  output logic bad
);
  logic [13:0] mag;
  always_comb
  begin
    mag = 14'(mag_bcd[15:12]) * 14'h03E8 + 14'(mag_bcd[11:8]) * 14'h0064
        + 14'(mag_bcd[7:4]) * 14'h000A + 14'(mag_bcd[3:0]);
    bad = sign_dig > ars_pkg::SIGN_RESET;
    for (int i = 0; i < 4; i++)
    begin
      if (mag_bcd[4*i +: 4] > 4'h9)
        bad = 1'b1;
    end
    is_reset = sign_dig == ars_pkg::SIGN_RESET;
    // One means negative, zero positive
    if (sign_dig == ars_pkg::SIGN_NEG)
      value = -$signed({1'b0, mag});
    else
      value = $signed({1'b0, mag});
  end
endmodule : ars_digits

// *** ars_interp.sv ***
// Purpose: zero + (full - zero) * code / 255, rounded to nearest
// Assumes: start only while no conversion runs
// Notes: restoring divider, one quotient bit per cycle
`timescale 1ns/100ps
module ars_interp (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rstn,
  // Request
  input wire logic start,
  input wire logic signed [14:0] zero_pt,
  input wire logic signed [14:0] full_pt,
  input wire logic [7:0] code,
  // Answer
  output logic done,
  output logic signed [15:0] value
);
  logic signed [15:0] zero_r, zero_nxt, value_r, value_nxt, diff;
  logic [14:0] mag;
  logic [22:0] dvd_r, dvd_nxt;
  logic [8:0] rem_r, rem_nxt, t;
  logic [4:0] cnt_r, cnt_nxt;
  logic neg_r, neg_nxt, busy_r, busy_nxt, done_r, done_nxt;
  // ***************************************************
  // Divider step
  // ***************************************************
  always_comb
  begin
    diff = 16'(full_pt) - 16'(zero_pt);
    mag = diff[15] ? 15'(-diff) : diff[14:0];
    t = {rem_r[7:0], dvd_r[22]};
    zero_nxt = zero_r;
    neg_nxt = neg_r;
    dvd_nxt = dvd_r;
    rem_nxt = rem_r;
    cnt_nxt = cnt_r;
    busy_nxt = busy_r;
    done_nxt = 1'b0;
    value_nxt = value_r;
    if (start)
    begin
      // Rounding bias keeps code 255 exact and code 0 at zero
      dvd_nxt = 23'(mag) * 23'(code) + ars_pkg::ROUND_HALF;
      rem_nxt = 9'h000;
      cnt_nxt = 5'h00;
      neg_nxt = diff[15];
      zero_nxt = 16'(zero_pt);
      busy_nxt = 1'b1;
    end
    else if (busy_r)
    begin
      rem_nxt = (t >= ars_pkg::ADC_DIVISOR) ? t - ars_pkg::ADC_DIVISOR : t;
      dvd_nxt = {dvd_r[21:0], t >= ars_pkg::ADC_DIVISOR};
      cnt_nxt = cnt_r + 5'h01;
      if (cnt_r == ars_pkg::DIV_STEPS - 5'h01)
      begin
        busy_nxt = 1'b0;
        done_nxt = 1'b1;
        value_nxt = neg_r ? zero_r - 16'(dvd_nxt[14:0]) : zero_r + 16'(dvd_nxt[14:0]);
      end
    end
  end
  always_ff @(posedge ref_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      zero_r <= 16'h0000;
      neg_r <= 1'b0;
      dvd_r <= 23'h000000;
      rem_r <= 9'h000;
      cnt_r <= 5'h00;
      busy_r <= 1'b0;
      done_r <= 1'b0;
      value_r <= 16'h0000;
    end
    else
    begin
      zero_r <= zero_nxt;
      neg_r <= neg_nxt;
      dvd_r <= dvd_nxt;
      rem_r <= rem_nxt;
      cnt_r <= cnt_nxt;
      busy_r <= busy_nxt;
      done_r <= done_nxt;
      value_r <= value_nxt;
    end
  end
  assign done = done_r;
  assign value = value_r;
  // ***************************************************
  // Checks
  // ***************************************************
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (!rstn);
  sequence s_code_zero;
    start && code == 8'h00;
  endsequence
  sequence s_code_top;
    start && code == 8'hFF;
  endsequence
  a_conv_latency:
    assert property (start |-> !done_r [*8] ##17 done_r)
    else $error("interpolation answer not after 24 cycles");
  a_code_zero_point:
    assert property (s_code_zero |-> ##24 (done_r && value_r == 16'($past(zero_pt, 24))))
    else $error("code zero does not give the zero point");
  a_code_top_point:
    assert property (s_code_top |-> ##24 (done_r && value_r == 16'($past(full_pt, 24))))
    else $error("top code does not give the full scale point");
endmodule : ars_interp

// *** ars_adc_model.sv ***
// Purpose: behavioural converter that offers samples to the scaler
// Assumes: one sample outstanding, handshake on adc_ready at the rising edge
// Notes: lines and code go to their inverse once a sample is taken
`timescale 1ns/100ps
module ars_adc_model (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rstn,
  // Bench request
  input wire logic req,
  input wire logic [2:0] req_line,
  input wire logic [7:0] req_code,
  // Converter side
  input wire logic adc_ready,
  output logic adc_valid,
  output logic [2:0] adc_line,
  output logic [7:0] adc_code
);
  always_ff @(posedge ref_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      adc_valid <= 1'b0;
      adc_line <= 3'h0;
      adc_code <= 8'h00;
    end
    else if (adc_valid && adc_ready)
    begin
      // Released lines must not keep the old value, or a late capture would pass
      adc_valid <= 1'b0;
      adc_line <= ~adc_line;
      adc_code <= ~adc_code;
    end
    else if (req && !adc_valid)
    begin
      adc_valid <= 1'b1;
      adc_line <= req_line;
      adc_code <= req_code;
    end
  end
endmodule : ars_adc_model

// *** tb_top.sv ***
// Purpose: self-checking bench for the analog reading scaler
// Assumes: register port and converter model on ref_clk
// Notes: expected readings are rebuilt from the points by bench functions
`timescale 1ns/100ps
module tb_top;
  logic ref_clk = 1'b0;
  logic rstn = 1'b0;
  logic [7:0] reg_addr = 8'h00;
  logic [31:0] reg_wdata = 32'h00000000;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [31:0] reg_rdata;
  logic req = 1'b0;
  logic [2:0] req_line = 3'h1;
  logic [7:0] req_code = 8'h00;
  logic adc_valid, adc_ready, rdg_valid, rdg_divided;
  logic [2:0] adc_line, rdg_line;
  logic [7:0] adc_code;
  logic signed [17:0] rdg_value;
  logic [1:0] rdg_decimals;
  int err_count = 0;
  int total_checks = 0;
  int seed = 32'h903d;
  int last [1:4] = '{0, 0, 0, 0};
  int corr [1:4] = '{0, 0, 0, 0};
  always #2.5 ref_clk = ~ref_clk;
  ars_scaler i_dut (.ref_clk(ref_clk), .rstn(rstn), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .adc_valid(adc_valid), .adc_line(adc_line),
    .adc_code(adc_code), .adc_ready(adc_ready), .rdg_valid(rdg_valid), .rdg_line(rdg_line),
    .rdg_value(rdg_value), .rdg_decimals(rdg_decimals), .rdg_divided(rdg_divided));
  ars_adc_model i_adc (.ref_clk(ref_clk), .rstn(rstn), .req(req), .req_line(req_line), .req_code(req_code),
    .adc_ready(adc_ready), .adc_valid(adc_valid), .adc_line(adc_line), .adc_code(adc_code));
  // ***************************************************
  // Expectations and reporting
  // ***************************************************
  function automatic int conv_of(input int z, input int f, input int c);
    int q;
    q = ((f > z ? f - z : z - f) * c + 127) / 255;
    return (f < z) ? z - q : z + q;
  endfunction : conv_of
  function automatic logic [31:0] digits(input int v);
    int m;
    m = (v < 0) ? -v : v;
    return {12'h000, (v < 0) ? 4'h1 : 4'h0, 4'(m / 1000), 4'(m / 100 % 10), 4'(m / 10 % 10), 4'(m % 10)};
  endfunction : digits
  task automatic finish_test();
    $display("checks %0d mismatches %0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : finish_test
  task automatic chk(input string name, input logic [31:0] e, input logic [31:0] g);
    total_checks++;
    if (g !== e)
    begin
      err_count++;
      $display("mismatch %s expected %0h seen %0h", name, e, g);
    end
  endtask : chk
  // ***************************************************
  // Bus and converter tasks
  // ***************************************************
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge ref_clk);
    reg_wr <= 1'b0;
  endtask : wr
  task automatic rd(input logic [7:0] a, output logic [31:0] q);
    @(posedge ref_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge ref_clk);
    reg_rd <= 1'b0;
    #1 q = reg_rdata;
  endtask : rd
  task automatic conv(input int l, input int c, input int ex, input int p, input logic dv);
    int k;
    @(posedge ref_clk);
    req <= 1'b1;
    req_line <= 3'(l);
    req_code <= 8'(c);
    @(posedge ref_clk);
    req <= 1'b0;
    for (k = 0; k < 40 && rdg_valid !== 1'b1; k++)
    begin
      @(posedge ref_clk);
      #1;
    end
    if (rdg_valid !== 1'b1)
    begin
      err_count++;
      finish_test();
    end
    else
    begin
      chk("rdg_value", 32'(ex), {{14{rdg_value[17]}}, rdg_value});
      chk("rdg_line", 32'(l), {29'h0, rdg_line});
      chk("rdg_decimals", 32'(p), {30'h0, rdg_decimals});
      chk("rdg_divided", {31'h0, dv}, {31'h0, rdg_divided});
      chk("adc_ready", 32'h1, {31'h0, adc_ready});
    end
  endtask : conv
  task automatic setup(input int l, input int z, input int f, input int p, input logic dv);
    wr(ars_pkg::A_LINE_SEL, 32'(l));
    wr(ars_pkg::A_PREC_ARG, 32'(p));
    wr(ars_pkg::A_COMMAND, {28'h0, ars_pkg::CMD_PREC});
    wr(ars_pkg::A_ZERO_ARG, digits(z));
    wr(ars_pkg::A_FULL_ARG, digits(f) | {11'h0, dv, 20'h0});
    wr(ars_pkg::A_COMMAND, {28'h0, ars_pkg::CMD_POINTS});
  endtask : setup
  // ***************************************************
  // Main sequence
  // ***************************************************
  initial
  begin
    repeat (100000) @(posedge ref_clk);
    err_count++;
    finish_test();
  end
  initial
  begin
    int i, l, z, f, p, c, cv;
    logic dv;
    logic [31:0] q;
    repeat (12) @(posedge ref_clk);
    rstn <= 1'b1;
    rd(ars_pkg::A_LINE_CFG, q);
    chk("line_cfg", 32'h0, q);
    rd(ars_pkg::A_OFFSET, q);
    chk("offset", 32'h0, q);
    rd(8'h3C, q);
    chk("unmapped", 32'h0, q);
    conv(1, 255, 5, 0, 1'b0);
    for (i = 0; i < 12; i++)
    begin
      l = 1 + $unsigned($random(seed)) % 4;
      z = $random(seed) % 10000;
      f = $random(seed) % 10000;
      p = $unsigned($random(seed)) % 4;
      dv = 1'($random(seed));
      c = (i == 0) ? 0 : (i == 1) ? 255 : $unsigned($random(seed)) % 256;
      // Points and precision go first; odd passes then calibrate, and a line's offset carries over to its later points
      setup(l, z, f, p, dv);
      rd(ars_pkg::A_STATUS, q);
      chk("status", 32'h4, q);
      last[l] = conv_of(z, f, c);
      conv(l, c, last[l] + corr[l], p, dv);
      rd(ars_pkg::A_RESULT, q);
      chk("result", 32'(last[l] + corr[l]), q);
      if (i % 2 == 1)
      begin
        cv = $random(seed) % 60;
        wr(ars_pkg::A_CAL_ARG, (i == 7) ? 32'h00020000 : digits(cv));
        wr(ars_pkg::A_COMMAND, {28'h0, ars_pkg::CMD_CAL});
        corr[l] = (i == 7) ? 0 : cv - last[l];
        rd(ars_pkg::A_OFFSET, q);
        chk("offset", 32'(corr[l]), q);
        rd(ars_pkg::A_RESULT, q);
        chk("result", 32'(last[l] + corr[l]), q);
      end
      $display("test %0d done", i);
    end
    wr(ars_pkg::A_LINE_SEL, 32'h5);
    wr(ars_pkg::A_COMMAND, {28'h0, ars_pkg::CMD_PREC});
    rd(ars_pkg::A_STATUS, q);
    chk("status", 32'h2, q);
    wr(ars_pkg::A_LINE_SEL, 32'h1);
    wr(ars_pkg::A_PREC_ARG, 32'h4);
    wr(ars_pkg::A_COMMAND, {28'h0, ars_pkg::CMD_PREC});
    rd(ars_pkg::A_STATUS, q);
    chk("status", 32'h2, q);
    wr(ars_pkg::A_ZERO_ARG, 32'h000000A0);
    wr(ars_pkg::A_COMMAND, {28'h0, ars_pkg::CMD_POINTS});
    rd(ars_pkg::A_STATUS, q);
    chk("status", 32'h2, q);
    $display("test reject done");
    finish_test();
  end
endmodule : tb_top
